// *** hw/pmo_macrocell.sv ***
// Output macrocell: two flip-flops, three four-term sum terms, term
// splitting, feedback selection, polarity and clock gating.
// Assumes all inputs are synchronous to clk; the product-term clocks are
// array signals whose rising edges are detected against clk.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - Registered mode drives first flop out; splits 8/4, 12/4, 8/4.
// R2 - Combinatorial, split 00: output is 8 terms, feedback from second flop.
// R3 - Combinatorial, split 01: output is 4 terms, feedback from second flop.
// R4 - Combinatorial, split 10: output is 12 terms, feedback from second flop.
// R5 - Combinatorial, split 11, second type 1: 8 terms, feedback second input.
// R6 - Combinatorial, split 11, second type 0: 4 terms, feedback second input.
// R7 - Extra term groups are shared with the first flop input, not duplicated.
// R8 - Polarity bit 0 drives output active low, 1 active high.
// R9 - First flop is D-type for type bit 0, T-type for 1.
// R10 - Second flop is D-type for type bit 0, T-type for 1.
// R11 - First flop clocks on its term clock, or term ANDed with clock pin.
// R12 - Second flop clocks on its term clock, or term ANDed with clock pin.
// R13 - A T-type flop toggles on its clock when its input is true, else holds.
module pmo_macrocell (
  input  wire logic              clk,                 // 200 MHz clock
  input  wire logic              rst,                 // Sync reset, high
  input  wire pmo_pkg::pmo_cfg_s cfg,                 // Configuration bits
  input  wire pmo_pkg::pmo_terms_s terms,             // Twelve product terms
  input  wire logic              first_term_clock,    // First flop clock term
  input  wire logic              second_term_clock,   // Second flop clock term
  input  wire logic              dedicated_clock_pin, // Shared clock pin
  output logic                   pin_out,             // Macrocell pin level
  output logic                   array_feedback,      // Feedback to array
  output logic                   first_flop_out,      // First flop state
  output logic                   second_flop_out      // Second flop state
);

  logic       sum_a;
  logic       sum_b;
  logic       sum_c;
  logic [1:0] split;
  logic       comb_mode;
  logic       first_flop_input_sum;
  logic       second_flop_input_sum;
  logic       comb_func;
  logic       out_func;
  logic       next_pin_out;
  logic       fb_from_input;
  logic       next_array_feedback;
  logic       clk1_level;
  logic       clk2_level;
  logic       clk1_prev;
  logic       clk2_prev;
  logic       clk1_event;
  logic       clk2_event;
  logic       next_first;
  logic       next_second;

  // Flop update shared by both registers; T-type XORs, D-type loads.
  function automatic logic flop_next(input logic q, input logic din,
                                     input logic is_t);
    flop_next = is_t ? (q ^ din) : din;
  endfunction

  assign sum_a     = |terms.group_a;
  assign sum_b     = |terms.group_b;
  assign sum_c     = |terms.group_c;
  assign split     = {cfg.term_split_select_high, cfg.term_split_select_low};
  assign comb_mode = cfg.combinatorial_select;

  // In combinatorial mode the first flop keeps only its own four terms;
  // the other groups go to the output function instead.
  // Split 01 is not defined for registered mode and is treated as 8/4.
  assign first_flop_input_sum = comb_mode ? sum_a :
      (split == pmo_pkg::SPLIT_12_4) ? (sum_a | sum_b | sum_c) : // R1 R7
      (sum_a | sum_b); // R1
  assign second_flop_input_sum = sum_c;

  // The wider functions reuse the very same sum terms that feed the
  // flops, so no term group is ever duplicated.
  assign comb_func =
      (split == pmo_pkg::SPLIT_8_4)  ? (sum_a | sum_b) :         // R2 R7
      (split == pmo_pkg::SPLIT_4_4)  ? sum_b :                   // R3
      (split == pmo_pkg::SPLIT_12_4) ? (sum_a | sum_b | sum_c) : // R4 R7
      cfg.second_reg_type_bit        ? (sum_a | sum_b) :         // R5
      sum_b; // R6

  assign out_func     = comb_mode ? comb_func : first_flop_out; // R1
  assign next_pin_out = (cfg.output_polarity_bit == pmo_pkg::POL_ACTIVE_HIGH)
                        ? out_func : ~out_func; // R8

  assign fb_from_input       = (split == pmo_pkg::SPLIT_INPUT_FB);
  assign next_array_feedback = fb_from_input ? second_flop_input_sum
                                             : second_flop_out; // R1 R5 R6

  // Gated clock levels; a flop fires on a rising edge of its level.
  assign clk1_level = first_term_clock &
      (cfg.first_clock_gate_bit ? dedicated_clock_pin : 1'h1); // R11
  assign clk2_level = second_term_clock &
      (cfg.second_clock_gate_bit ? dedicated_clock_pin : 1'h1); // R12
  assign clk1_event = clk1_level & ~clk1_prev; // R11
  assign clk2_event = clk2_level & ~clk2_prev; // R12

  assign next_first  = clk1_event ?
      flop_next(first_flop_out, first_flop_input_sum,
                cfg.first_reg_type_bit) : first_flop_out; // R9 R13
  assign next_second = clk2_event ?
      flop_next(second_flop_out, second_flop_input_sum,
                cfg.second_reg_type_bit) : second_flop_out; // R10 R13

  always_ff @(posedge clk) begin
    if (rst) begin
      clk1_prev       <= 1'h0;
      clk2_prev       <= 1'h0;
      first_flop_out  <= pmo_pkg::FLOP_RESET;
      second_flop_out <= pmo_pkg::FLOP_RESET;
    end else begin
      clk1_prev       <= clk1_level;
      clk2_prev       <= clk2_level;
      first_flop_out  <= next_first;
      second_flop_out <= next_second;
    end
  end

  // The pin and feedback are registered so every output leaves a flop;
  // this costs one cycle of latency on combinatorial paths.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out        <= pmo_pkg::FLOP_RESET;
      array_feedback <= pmo_pkg::FLOP_RESET;
    end else begin
      pin_out        <= next_pin_out;
      array_feedback <= next_array_feedback;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_reg_mode;
    !comb_mode;
  endsequence

  sequence s_comb_split(logic [1:0] s);
    comb_mode && split == s;
  endsequence

  property p_registered_out;
    s_reg_mode |=> pin_out == ($past(cfg.output_polarity_bit)
        ? $past(first_flop_out) : ~$past(first_flop_out));
  endproperty
  a_registered_out: assert property (p_registered_out) // R1
    else $error("registered pin does not follow first flop");

  property p_comb_8;
    s_comb_split(2'h0) ##0 cfg.output_polarity_bit |=>
        pin_out == $past(sum_a | sum_b);
  endproperty
  a_comb_8: assert property (p_comb_8) // R2
    else $error("eight term output wrong");

  property p_comb_4;
    s_comb_split(2'h1) ##0 !cfg.output_polarity_bit |=>
        pin_out == ~$past(sum_b);
  endproperty
  a_comb_4: assert property (p_comb_4) // R3
    else $error("four term output wrong");

  property p_comb_12;
    s_comb_split(2'h2) ##0 cfg.output_polarity_bit |=>
        pin_out == $past(sum_a | sum_b | sum_c);
  endproperty
  a_comb_12: assert property (p_comb_12) // R4
    else $error("twelve term output wrong");

  property p_comb_in_fb_8;
    s_comb_split(2'h3) ##0 cfg.second_reg_type_bit &&
        cfg.output_polarity_bit |=>
        pin_out == $past(sum_a | sum_b) && array_feedback == $past(sum_c);
  endproperty
  a_comb_in_fb_8: assert property (p_comb_in_fb_8) // R5
    else $error("split 11 eight term mode wrong");

  property p_comb_in_fb_4;
    s_comb_split(2'h3) ##0 !cfg.second_reg_type_bit &&
        cfg.output_polarity_bit |=>
        pin_out == $past(sum_b) && array_feedback == $past(sum_c);
  endproperty
  a_comb_in_fb_4: assert property (p_comb_in_fb_4) // R6
    else $error("split 11 four term mode wrong");

  property p_q2_feedback;
    split != 2'h3 |=> array_feedback == $past(second_flop_out);
  endproperty
  a_q2_feedback: assert property (p_q2_feedback) // R2
    else $error("feedback not from second flop");

  // A D-type load in 12/4 mode must see all three groups, the third being
  // the very group that also feeds the second flop.
  property p_shared_12;
    s_reg_mode ##0 split == 2'h2 ##0 clk1_event ##0
        !cfg.first_reg_type_bit |=>
        first_flop_out == $past(sum_a | sum_b | sum_c);
  endproperty
  a_shared_12: assert property (p_shared_12) // R7
    else $error("twelve term input not shared");

  property p_first_d;
    clk1_event && !cfg.first_reg_type_bit |=>
        first_flop_out == $past(first_flop_input_sum);
  endproperty
  a_first_d: assert property (p_first_d) // R9
    else $error("first D flop did not load");

  property p_second_t;
    clk2_event && cfg.second_reg_type_bit |=>
        second_flop_out == ($past(second_flop_out) ^ $past(sum_c));
  endproperty
  a_second_t: assert property (p_second_t) // R10
    else $error("second T flop did not toggle");

  property p_first_hold;
    !clk1_event |=> $stable(first_flop_out);
  endproperty
  a_first_hold: assert property (p_first_hold) // R13
    else $error("first flop changed without a clock");

  sequence s_gated_rise;
    cfg.first_clock_gate_bit && !dedicated_clock_pin ##1
        cfg.first_clock_gate_bit && !dedicated_clock_pin;
  endsequence

  property p_gate_blocks;
    s_gated_rise |=> $stable(first_flop_out);
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) // R11
    else $error("first flop clocked with pin low");

  property p_second_gate_blocks;
    cfg.second_clock_gate_bit && !dedicated_clock_pin |=>
        $stable(second_flop_out) || $past(clk2_prev);
  endproperty
  a_second_gate_blocks: assert property (p_second_gate_blocks) // R12
    else $error("second flop clocked with pin low");

endmodule

`default_nettype wire

// *** hw/pmo_pkg.sv ***
// Package for the configurable output macrocell: configuration layout,
// term-split selections and widths shared by the design.
// Assumes a single 200 MHz clock domain and synchronous array inputs.
`default_nettype none
package pmo_pkg;

  // Product terms per sum term; three sum terms per macrocell.
  localparam int unsigned TERMS_PER_SUM = 4;
  localparam int unsigned CFG_WIDTH     = 8;

  // Term-split selections, high bit then low bit.
  localparam logic [1:0] SPLIT_8_4      = 2'h0;
  localparam logic [1:0] SPLIT_4_4      = 2'h1;
  localparam logic [1:0] SPLIT_12_4     = 2'h2;
  localparam logic [1:0] SPLIT_INPUT_FB = 2'h3;

  // Polarity and type encodings.
  localparam logic POL_ACTIVE_LOW  = 1'h0;
  localparam logic POL_ACTIVE_HIGH = 1'h1;
  localparam logic REG_TYPE_D      = 1'h0;
  localparam logic REG_TYPE_T      = 1'h1;
  localparam logic CLK_TERM_ONLY   = 1'h0;
  localparam logic CLK_TERM_PIN    = 1'h1;

  // Reset values of the two flip-flops and the registered outputs.
  localparam logic FLOP_RESET = 1'h0;

  typedef struct packed {
    logic second_clock_gate_bit;
    logic first_clock_gate_bit;
    logic second_reg_type_bit;
    logic first_reg_type_bit;
    logic output_polarity_bit;
    logic combinatorial_select;
    logic term_split_select_high;
    logic term_split_select_low;
  } pmo_cfg_s;

  typedef struct packed {
    logic [TERMS_PER_SUM-1:0] group_c;
    logic [TERMS_PER_SUM-1:0] group_b;
    logic [TERMS_PER_SUM-1:0] group_a;
  } pmo_terms_s;

endpackage

`default_nettype wire

// *** sim/pmo_macrocell_test.sv ***
// Self-checking bench for the output macrocell: sweeps the combinatorial
// modes, then steps the two flip-flops through D, T and gated clocking.
// Assumes the one-cycle registered outputs described for the block.
`timescale 1ns/1ps
`default_nettype none
module pmo_macrocell_test;
  logic                clk;
  logic                rst;
  pmo_pkg::pmo_cfg_s   cfg;
  pmo_pkg::pmo_terms_s terms;
  logic                first_term_clock;
  logic                second_term_clock;
  logic                dedicated_clock_pin;
  logic                pin_out;
  logic                array_feedback;
  logic                first_flop_out;
  logic                second_flop_out;
  int                  miscompares;
  int                  checks;
  logic                f;
  logic [11:0]         t;

  pmo_macrocell i_dut (
    .clk                 (clk),
    .rst                 (rst),
    .cfg                 (cfg),
    .terms               (terms),
    .first_term_clock    (first_term_clock),
    .second_term_clock   (second_term_clock),
    .dedicated_clock_pin (dedicated_clock_pin),
    .pin_out             (pin_out),
    .array_feedback      (array_feedback),
    .first_flop_out      (first_flop_out),
    .second_flop_out     (second_flop_out)
  );

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic finish_test();
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apply(input logic [7:0] c, input logic [11:0] tm,
                       input logic pn);
    @(posedge clk);
    cfg <= pmo_pkg::pmo_cfg_s'(c);
    terms <= pmo_pkg::pmo_terms_s'(tm);
    dedicated_clock_pin <= pn;
  endtask

  // The term clock is dropped again after one cycle, so every step gives
  // at most one event per flop and leaves the term low for the next step.
  task automatic step(input logic [7:0] c, input logic [11:0] tm,
                      input logic k1, input logic k2, input logic pn,
                      input logic e1, input logic e2);
    apply(c, tm, pn);
    @(posedge clk);
    first_term_clock <= k1;
    second_term_clock <= k2;
    @(posedge clk);
    first_term_clock <= 1'h0;
    second_term_clock <= 1'h0;
    @(posedge clk);
    #1;
    chk("first_flop_out", e1, first_flop_out);
    chk("second_flop_out", e2, second_flop_out);
    chk("pin_out", c[3] ? e1 : ~e1, pin_out);
    chk("array_feedback", (c[1:0] == 2'h3) ? (|tm[11:8]) : e2,
        array_feedback);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    rst = 1'h1;
    cfg = '0;
    terms = '0;
    first_term_clock = 1'h0;
    second_term_clock = 1'h0;
    dedicated_clock_pin = 1'h0;
    miscompares = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    // Cleared first flop with active-low polarity drives the pin high.
    chk("pin_out", 1'h1, pin_out);
    // Split value, then mode bits: m[0] polarity, m[1] second type.
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 4; m++) begin
        for (int p = 0; p < 8; p++) begin
          t = {p[2] ? 4'h8 : 4'h0, p[1] ? 4'h4 : 4'h0, p[0] ? 4'h1 : 4'h0};
          case (s)
            0: f = p[0] | p[1];
            1: f = p[1];
            2: f = p[0] | p[1] | p[2];
            default: f = m[1] ? (p[0] | p[1]) : p[1];
          endcase
          apply({2'h0, m[1], 1'h0, m[0], 1'h1, s[1:0]}, t, 1'h0);
          repeat (2) @(posedge clk);
          #1;
          chk("pin_out", m[0] ? f : ~f, pin_out);
          chk("array_feedback", p[2] & (s == 3),
              array_feedback);
        end
      end
    end
    step(8'h08, 12'h001, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    step(8'h08, 12'h800, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
    step(8'h0A, 12'h800, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    step(8'h0B, 12'h040, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
    step(8'h03, 12'h800, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
    step(8'h18, 12'h001, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    step(8'h18, 12'h001, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    step(8'h18, 12'h000, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    step(8'h28, 12'h800, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    step(8'h28, 12'h800, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    step(8'h28, 12'h000, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    step(8'h48, 12'h000, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    step(8'h48, 12'h000, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    step(8'h88, 12'h800, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    step(8'h88, 12'h800, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
    // A second reset in mid-run must clear the set second flop again.
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk("second_flop_out", 1'h0, second_flop_out);
    finish_test();
  end
endmodule
`default_nettype wire
